/* logic/prr_pkg.sv */
/*
  shared constants of the time-of-day counter: register offsets, field widths,
  reset values and the timing figures of the derived tick.
  assumes nothing of its surroundings; every file refers to it as prr_pkg::name.
*/
package prr_pkg;
  // register byte offsets
  localparam logic [16:0] PRR_OFS_NS_OFFSET = 17'h12800;   // nanoseconds step value, write loads counter
  localparam logic [16:0] PRR_OFS_SEC_OFS_LO = 17'h12808;  // seconds step value bits 31:0
  localparam logic [16:0] PRR_OFS_SEC_OFS_HI = 17'h1280C;  // seconds step value bits 47:32
  localparam logic [16:0] PRR_OFS_INC_RATE = 17'h12810;    // time_increment_rate
  localparam logic [16:0] PRR_OFS_NS_NOW = 17'h12814;      // time_nanoseconds_now
  localparam logic [16:0] PRR_OFS_SEC_LO_NOW = 17'h12818;  // time_seconds_low_now
  localparam logic [16:0] PRR_OFS_SEC_HI_NOW = 17'h1281C;  // time_seconds_high_now
  localparam logic [16:0] PRR_OFS_IRQ_CLEAR = 17'h12820;   // timer_irq_clear
  localparam logic [16:0] PRR_OFS_PHASE = 17'h12824;       // timing_phase_offset
  // field widths
  localparam int PRR_INC_W = 26;   // increment field 25:0
  localparam int PRR_FRAC_W = 20;  // fraction bits, 1/2^20 ns
  localparam int PRR_NS_W = 30;    // nanoseconds field 29:0
  localparam int PRR_SEC_W = 48;   // seconds count
  localparam int PRR_SEC_HI_W = 16; // upper seconds field 15:0
  localparam int PRR_IRQ_CLR_BIT = 0; // clear bit position
  // reset values
  localparam logic [25:0] PRR_INC_RESET = 26'h0000000;
  localparam logic [29:0] PRR_NS_RESET = 30'h00000000;
  localparam logic [47:0] PRR_SEC_RESET = 48'h000000000000;
  localparam logic [29:0] PRR_PHASE_RESET = 30'h00000000;
  // timing figures
  localparam logic [29:0] PRR_NS_PER_SEC = 30'h3B9ACA00;   // one billion ns
  localparam logic [30:0] PRR_TICK_PERIOD_NS = 31'h0001E848; // 125000 ns, 8 kHz
  localparam logic [30:0] PRR_TICK_HALF_NS = 31'h0000F424;   // 62500 ns
endpackage : prr_pkg

/* logic/prr_tick_gen.sv */
/*
  derives the 8 kHz tick from the nanoseconds count plus the phase offset.
  assumes ns_now is below one billion and phase is a 30-bit value; one clock.
*/
`timescale 1ns/10ps
module prr_tick_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [29:0] ns_now,
  input wire logic [29:0] phase_ns,
  output logic eight_khz_tick
);
  logic [30:0] sum_raw;    // ns plus phase, up to 31 bits
  logic [30:0] sum_wrap;   // sum folded into one second
  logic [30:0] in_period;  // position inside the 125 us period
  logic tick_d;            // next tick level
  logic tick_q;            // registered tick

  // phase-adjusted time, high during the first half of each period
  always_comb begin
    sum_raw = {1'b0, ns_now} + {1'b0, phase_ns};
    if (sum_raw >= {1'b0, prr_pkg::PRR_NS_PER_SEC}) begin
      sum_wrap = sum_raw - {1'b0, prr_pkg::PRR_NS_PER_SEC};
    end else begin
      sum_wrap = sum_raw;
    end
    in_period = sum_wrap % prr_pkg::PRR_TICK_PERIOD_NS;
    tick_d = (in_period < prr_pkg::PRR_TICK_HALF_NS);
  end

  // tick register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign eight_khz_tick = tick_q;

  // a half-period phase shift flips the tick level
  property p_tick_half;
    @(posedge clk_sys) disable iff (!rst_n)
      (((({1'b0, ns_now} + {1'b0, phase_ns}) % prr_pkg::PRR_TICK_PERIOD_NS) == 31'h0000F424))
      |=> !tick_q;
  endproperty
  a_tick_half: assert property (p_tick_half) else $error("tick high at half period");

  property p_tick_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (((({1'b0, ns_now} + {1'b0, phase_ns}) % prr_pkg::PRR_TICK_PERIOD_NS) == 31'h00000000))
      |=> tick_q;
  endproperty
  a_tick_zero: assert property (p_tick_zero) else $error("tick low at period start");

  c_tick_rise: cover property (@(posedge clk_sys) disable iff (!rst_n) !tick_q ##1 tick_q);
endmodule : prr_tick_gen

/* logic/prr_rtc.sv */
/*
  time-of-day counter with snapshot readout, periodic timer interrupt,
  step loading and a phase-shifted 8 kHz tick.
  assumes a simple register port: one-cycle read or write strobes with a byte
  address; read data answers one cycle later with reg_rvalid. single clock.
*/
// Contract
// - add increment to counter every clock; a nanoseconds offset write loads the counter instead
// - increment counts 1/2^20 nanosecond units
// - nanoseconds read snapshots whole seconds count
// - nanoseconds read: 30 bits, top zero
// - low seconds read returns snapshot bits 31:0
// - high seconds read returns snapshot bits 47:32
// - periodic timer interrupt held until cleared
// - any write to clear register drops interrupt, unless a second boundary is crossed in the same cycle
// - clear register reads as zero
// - tick derived from nanoseconds plus phase
// - 8 kHz tick, 62500 phase inverts it
// - nanoseconds offset write loads all offsets
// - offsets: 30-bit ns, 48-bit seconds split
`timescale 1ns/10ps
module prr_rtc (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [16:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic interrupt_timer,
  output logic eight_khz_tick
);
  localparam int ACC_W = prr_pkg::PRR_NS_W + prr_pkg::PRR_FRAC_W; // fixed-point ns width
  localparam logic [ACC_W:0] WRAP_FX = {21'h000000, prr_pkg::PRR_NS_PER_SEC} << prr_pkg::PRR_FRAC_W;

  // software-written state
  logic [25:0] inc_q, inc_d;           // time_increment_rate
  logic [29:0] phase_q, phase_d;       // timing_phase_offset
  logic [29:0] ns_ofs_q, ns_ofs_d;     // nanoseconds step value
  logic [31:0] sec_ofs_lo_q, sec_ofs_lo_d; // seconds step low
  logic [15:0] sec_ofs_hi_q, sec_ofs_hi_d; // seconds step high
  // counter state
  logic [ACC_W-1:0] acc_q, acc_d;      // ns with 20 fraction bits
  logic [47:0] sec_q, sec_d;           // running seconds
  logic [47:0] snap_q, snap_d;         // seconds captured at ns read
  logic irq_q, irq_d;                  // timer interrupt
  logic [31:0] rdata_q, rdata_d;       // read answer
  logic rvalid_q, rvalid_d;            // read answer strobe
  // decode and arithmetic
  logic wr_ns_ofs;                     // write to nanoseconds step register
  logic wr_irq_clr;                    // write to clear register
  logic rd_ns_now;                     // read of nanoseconds now
  logic [ACC_W:0] acc_sum;             // count plus increment
  logic wrapped;                       // second boundary crossed

  assign wr_ns_ofs = reg_wr_en && (reg_addr == prr_pkg::PRR_OFS_NS_OFFSET);
  assign wr_irq_clr = reg_wr_en && (reg_addr == prr_pkg::PRR_OFS_IRQ_CLEAR);
  assign rd_ns_now = reg_rd_en && (reg_addr == prr_pkg::PRR_OFS_NS_NOW);
  assign acc_sum = {1'b0, acc_q} + {{(ACC_W + 1 - prr_pkg::PRR_INC_W){1'b0}}, inc_q};
  assign wrapped = !wr_ns_ofs && (acc_sum >= WRAP_FX);

  // register writes: configuration and step values
  always_comb begin
    inc_d = inc_q;
    phase_d = phase_q;
    ns_ofs_d = ns_ofs_q;
    sec_ofs_lo_d = sec_ofs_lo_q;
    sec_ofs_hi_d = sec_ofs_hi_q;
    if (reg_wr_en) begin
      case (reg_addr)
        prr_pkg::PRR_OFS_INC_RATE: inc_d = reg_wdata[25:0];
        prr_pkg::PRR_OFS_PHASE: phase_d = reg_wdata[29:0];
        prr_pkg::PRR_OFS_NS_OFFSET: ns_ofs_d = reg_wdata[29:0];
        prr_pkg::PRR_OFS_SEC_OFS_LO: sec_ofs_lo_d = reg_wdata;
        prr_pkg::PRR_OFS_SEC_OFS_HI: sec_ofs_hi_d = reg_wdata[15:0];
        default: inc_d = inc_q; // read-only or unmapped: ignored
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inc_q <= prr_pkg::PRR_INC_RESET;
      phase_q <= prr_pkg::PRR_PHASE_RESET;
      ns_ofs_q <= prr_pkg::PRR_NS_RESET;
      sec_ofs_lo_q <= 32'h00000000;
      sec_ofs_hi_q <= 16'h0000;
    end else begin
      inc_q <= inc_d;
      phase_q <= phase_d;
      ns_ofs_q <= ns_ofs_d;
      sec_ofs_lo_q <= sec_ofs_lo_d;
      sec_ofs_hi_q <= sec_ofs_hi_d;
    end
  end

  // counter: step load, else advance with one-second wrap
  always_comb begin
    if (wr_ns_ofs) begin
      // step takes the new ns value with the stored seconds halves together
      acc_d = {reg_wdata[29:0], {prr_pkg::PRR_FRAC_W{1'b0}}};
      sec_d = {sec_ofs_hi_q, sec_ofs_lo_q};
    end else if (wrapped) begin
      acc_d = ACC_W'(acc_sum - WRAP_FX);
      sec_d = sec_q + 48'h000000000001;
    end else begin
      acc_d = acc_sum[ACC_W-1:0];
      sec_d = sec_q;
    end
    // seconds captured on ns read so later halves are coherent
    snap_d = rd_ns_now ? sec_q : snap_q;
    // set on each second boundary; a set in the clear cycle wins
    if (wrapped) begin
      irq_d = 1'b1;
    end else if (wr_irq_clr) begin
      irq_d = 1'b0;
    end else begin
      irq_d = irq_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= {ACC_W{1'b0}};
      sec_q <= prr_pkg::PRR_SEC_RESET;
      snap_q <= prr_pkg::PRR_SEC_RESET;
      irq_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      sec_q <= sec_d;
      snap_q <= snap_d;
      irq_q <= irq_d;
    end
  end

  // read mux, answered one cycle after the strobe
  always_comb begin
    rvalid_d = reg_rd_en;
    rdata_d = 32'h00000000;
    if (reg_rd_en) begin
      case (reg_addr)
        prr_pkg::PRR_OFS_NS_OFFSET: rdata_d = {2'h0, ns_ofs_q};
        prr_pkg::PRR_OFS_SEC_OFS_LO: rdata_d = sec_ofs_lo_q;
        prr_pkg::PRR_OFS_SEC_OFS_HI: rdata_d = {16'h0000, sec_ofs_hi_q};
        prr_pkg::PRR_OFS_INC_RATE: rdata_d = {6'h00, inc_q};
        prr_pkg::PRR_OFS_NS_NOW: rdata_d = {2'h0, acc_q[ACC_W-1:prr_pkg::PRR_FRAC_W]};
        prr_pkg::PRR_OFS_SEC_LO_NOW: rdata_d = snap_q[31:0];
        prr_pkg::PRR_OFS_SEC_HI_NOW: rdata_d = {16'h0000, snap_q[47:32]};
        prr_pkg::PRR_OFS_IRQ_CLEAR: rdata_d = 32'h00000000;
        prr_pkg::PRR_OFS_PHASE: rdata_d = {2'h0, phase_q};
        default: rdata_d = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign interrupt_timer = irq_q;

  // phase-shifted tick generator
  prr_tick_gen u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ns_now(acc_q[ACC_W-1:prr_pkg::PRR_FRAC_W]),
    .phase_ns(phase_q),
    .eight_khz_tick(eight_khz_tick)
  );

  property p_advance;
    @(posedge clk_sys) disable iff (!rst_n)
      (!wr_ns_ofs && !wrapped) |=> (acc_q == ACC_W'($past(acc_q) + ACC_W'($past(inc_q))));
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance by increment");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      wrapped |=> (sec_q == $past(sec_q) + 48'h000000000001) && (acc_q < WRAP_FX[ACC_W-1:0]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("second wrap wrong");

  property p_load;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_ns_ofs |=> (acc_q[ACC_W-1:prr_pkg::PRR_FRAC_W] == $past(reg_wdata[29:0]))
        && (sec_q == {$past(sec_ofs_hi_q), $past(sec_ofs_lo_q)});
  endproperty
  a_load: assert property (p_load) else $error("step load wrong");

  property p_ns_read;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_ns_now |=> reg_rvalid && (reg_rdata[31:30] == 2'h0)
        && (reg_rdata[29:0] == $past(acc_q[ACC_W-1:prr_pkg::PRR_FRAC_W]));
  endproperty
  a_ns_read: assert property (p_ns_read) else $error("ns read data wrong");

  // low seconds read one idle edge after a nanoseconds read answers that read's seconds
  property p_snapshot;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_ns_now ##1 !rd_ns_now ##1 (reg_rd_en && reg_addr == prr_pkg::PRR_OFS_SEC_LO_NOW)
        |=> (reg_rdata == $past(sec_q[31:0], 3));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("seconds low not from snapshot");

  property p_sec_hi;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_rd_en && reg_addr == prr_pkg::PRR_OFS_SEC_HI_NOW)
        |=> (reg_rdata == {16'h0000, $past(snap_q[47:32])});
  endproperty
  a_sec_hi: assert property (p_sec_hi) else $error("seconds high read wrong");

  property p_irq_set;
    @(posedge clk_sys) disable iff (!rst_n)
      wrapped |=> interrupt_timer;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised at wrap");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (interrupt_timer && !wr_irq_clr) |=> interrupt_timer;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");

  property p_irq_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_irq_clr && !wrapped) |=> !interrupt_timer;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");

  property p_clr_reads_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_rd_en && reg_addr == prr_pkg::PRR_OFS_IRQ_CLEAR) |=> reg_rvalid && (reg_rdata == 32'h00000000);
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear register read not zero");

  c_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) wrapped);
  c_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
    interrupt_timer ##1 wr_irq_clr ##1 !interrupt_timer);
  c_snap: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rd_ns_now ##[1:4] (reg_rd_en && reg_addr == prr_pkg::PRR_OFS_SEC_HI_NOW));
endmodule : prr_rtc

/* verif/ptp_rtc_rate_readout_phase_bench.sv */
/*
  self-checking bench of the time-of-day counter: register reads and writes, snapshot
  readout, seconds rollover with its interrupt, fractional rate and the phase-shifted tick.
  assumes the prr_rtc register port of single-cycle strobes and the prr_pkg offsets.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module ptp_rtc_rate_readout_phase_bench;
  logic clk_sys;          // 100 MHz system clock
  logic rst_n;            // async reset, active low
  logic reg_wr_en;        // write strobe
  logic reg_rd_en;        // read strobe
  logic [16:0] reg_addr;  // byte address
  logic [31:0] reg_wdata; // write data
  logic [31:0] reg_rdata; // read data
  logic reg_rvalid;       // read answer
  logic interrupt_timer;  // periodic interrupt
  logic eight_khz_tick;   // derived tick
  int err_count = 0;      // mismatches
  int checks_done = 0;    // comparisons made
  int rd_n;               // negedges spent by the last read after its strobe
  logic [31:0] r0;        // first sampled value
  logic [31:0] r1;        // second sampled value

  prr_rtc u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .interrupt_timer(interrupt_timer),
    .eight_khz_tick(eight_khz_tick)
  );

  // free-running clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  // one write strobe, launched on a falling edge
  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask : wr

  // one read strobe, then a bounded wait for the answer
  task automatic rd(input logic [16:0] a, output logic [31:0] d);
    int n;
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    n = 1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(reg_rvalid, 1'b1)
    d = reg_rdata;
    rd_n = n;
  endtask : rd

  // read and compare against an expected word
  task automatic chk_rd(input logic [16:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, exp)
  endtask : chk_rd

  // sets the phase, loads the count with the rate at zero, checks the tick level
  task automatic tick_case(input logic [29:0] ns, input logic [29:0] ph);
    longint s;
    logic exp;
    s = (longint'(ns) + longint'(ph)) % 64'd1000000000;
    exp = ((s % 64'd125000) < 64'd62500);
    wr(prr_pkg::PRR_OFS_PHASE, {2'b00, ph});
    wr(prr_pkg::PRR_OFS_NS_OFFSET, {2'b00, ns});
    repeat (3) @(negedge clk_sys);
    `CHK(eight_khz_tick, exp)
  endtask : tick_case

  // prints the counts and the verdict, then ends the run
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    stop_test;
  end

  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 17'h00000;
    reg_wdata = 32'h00000000;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    // reset values and an unmapped place
    chk_rd(prr_pkg::PRR_OFS_INC_RATE, 32'h00000000);
    chk_rd(prr_pkg::PRR_OFS_NS_NOW, 32'h00000000);
    chk_rd(prr_pkg::PRR_OFS_SEC_LO_NOW, 32'h00000000);
    chk_rd(prr_pkg::PRR_OFS_SEC_HI_NOW, 32'h00000000);
    chk_rd(prr_pkg::PRR_OFS_PHASE, 32'h00000000);
    chk_rd(17'h12804, 32'h00000000);
    `CHK(interrupt_timer, 1'b0)
    $display("test reset values done");
    // field widths: reserved upper bits read zero
    wr(prr_pkg::PRR_OFS_PHASE, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_PHASE, 32'h3FFFFFFF);
    wr(prr_pkg::PRR_OFS_SEC_OFS_HI, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_SEC_OFS_HI, 32'h0000FFFF);
    wr(prr_pkg::PRR_OFS_IRQ_CLEAR, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_IRQ_CLEAR, 32'h00000000);
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_INC_RATE, 32'h03FFFFFF);
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'h00000000);
    $display("test field widths done");
    // step load and snapshot: a later load must not disturb the captured seconds
    wr(prr_pkg::PRR_OFS_SEC_OFS_LO, 32'h89ABCDEF);
    wr(prr_pkg::PRR_OFS_SEC_OFS_HI, 32'h00001234);
    wr(prr_pkg::PRR_OFS_NS_OFFSET, 32'h3B9AC618);
    chk_rd(prr_pkg::PRR_OFS_NS_NOW, 32'h3B9AC618);
    wr(prr_pkg::PRR_OFS_SEC_OFS_LO, 32'hFFFFFFFF);
    wr(prr_pkg::PRR_OFS_NS_OFFSET, 32'h3B9AC618);
    chk_rd(prr_pkg::PRR_OFS_SEC_LO_NOW, 32'h89ABCDEF);
    chk_rd(prr_pkg::PRR_OFS_SEC_HI_NOW, 32'h00001234);
    wr(prr_pkg::PRR_OFS_NS_NOW, 32'h00000005);
    chk_rd(prr_pkg::PRR_OFS_NS_NOW, 32'h3B9AC618);
    chk_rd(prr_pkg::PRR_OFS_SEC_LO_NOW, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_SEC_OFS_LO, 32'hFFFFFFFF);
    chk_rd(prr_pkg::PRR_OFS_NS_OFFSET, 32'h3B9AC618);
    `CHK(interrupt_timer, 1'b0)
    $display("test snapshot done");
    // rollover: 1000 ns short of a second at 10 ns a cycle, carry into the high seconds
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'h00A00000);
    repeat (150) @(negedge clk_sys);
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'h00000000);
    `CHK(interrupt_timer, 1'b1)
    rd(prr_pkg::PRR_OFS_NS_NOW, r0);
    `CHK((r0 < 32'd1000) && (r0 % 32'd10 == 32'd0), 1'b1)
    chk_rd(prr_pkg::PRR_OFS_SEC_LO_NOW, 32'h00000000);
    chk_rd(prr_pkg::PRR_OFS_SEC_HI_NOW, 32'h00001235);
    repeat (20) @(negedge clk_sys);
    `CHK(interrupt_timer, 1'b1)
    wr(prr_pkg::PRR_OFS_IRQ_CLEAR, 32'h00000000);
    repeat (2) @(negedge clk_sys);
    `CHK(interrupt_timer, 1'b0)
    $display("test rollover done");
    // fractional rate of 2.5 ns: two reads eight cycles apart differ by exactly 20 ns
    wr(prr_pkg::PRR_OFS_NS_OFFSET, 32'h00000000);
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'h00280000);
    rd(prr_pkg::PRR_OFS_NS_NOW, r0);
    repeat (7 - rd_n) @(negedge clk_sys);
    rd(prr_pkg::PRR_OFS_NS_NOW, r1);
    wr(prr_pkg::PRR_OFS_INC_RATE, 32'h00000000);
    `CHK(r1 - r0, 32'd20)
    $display("test fractional rate done");
    // tick level against nanoseconds plus phase, including the wrap at one second
    tick_case(30'd0, 30'd0);
    tick_case(30'd0, 30'd62500);
    tick_case(30'd0, 30'd62499);
    tick_case(30'd62500, 30'd0);
    tick_case(30'd124999, 30'd1);
    tick_case(30'd999937500, 30'd0);
    tick_case(30'd999999999, 30'd62501);
    $display("test tick phase done");
    stop_test;
  end
endmodule : ptp_rtc_rate_readout_phase_bench
